// ==== logic/scp_pkg.sv ====
// Notes on behaviour
// - gate write needs key 0xa32c in 31:16
// - five read-only event flags at 12:8
// - flag raises nmi only when enabled
// - enables at 4:0, reset leaves brownout on
// - pin enable off holds clock pin low
// - divider zero passes clock, else 2(d+1)
// - synth held reset/off; lock read-only
// - bypass zero routes input clock through
// - out = in / synth_input_divider * m / n
// - synth_input_divider bit: divide by one or two
// - feedback code picks m; 1100+ unavailable
// - post code picks n; 110 gives 3
// - source select picks internal or external
package scp_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int EVT_N  = 5;

    // register byte addresses
    localparam logic [31:0] COR_ADDR  = 32'h4000_0050;
    localparam logic [31:0] NMI_ADDR  = 32'h4000_0054;
    localparam logic [31:0] PLL_ADDR  = 32'h4000_0060;

    // event gate layout
    localparam logic [15:0] UNLOCK_KEY = 16'ha32c;
    localparam int KEY_HI  = 31;
    localparam int KEY_LO  = 16;
    localparam int FLAG_HI = 12;
    localparam int FLAG_LO = 8;
    localparam int EN_HI   = 4;
    localparam int EN_LO   = 0;
    localparam logic [4:0] EN_RST = 5'h01;

    // clock output layout
    localparam int PIN_EN_BIT = 4;
    localparam int PIN_DIV_HI = 3;
    localparam int PIN_DIV_LO = 0;
    localparam logic [3:0] PIN_DIV_RST = 4'h0;

    // synth control layout
    localparam int SYN_RREL_BIT = 15;
    localparam int SYN_EN_BIT   = 14;
    localparam int SYN_BYP_BIT  = 13;
    localparam int SYN_LOCK_BIT = 12;
    localparam int SYN_PRE_BIT  = 8;
    localparam int SYN_FB_HI    = 7;
    localparam int SYN_FB_LO    = 4;
    localparam int SYN_POST_HI  = 2;
    localparam int SYN_POST_LO  = 0;
    localparam logic [3:0] SYN_FB_LAST = 4'hb;
    localparam logic [3:0] SYN_FB_RST  = 4'h0;
    localparam logic [2:0] SYN_POST_RST = 3'h0;

    typedef struct packed {
        logic [31:0] rdata;
        logic [4:0]  evt_flag;
        logic [4:0]  evt_en;
        logic        nmi;
        logic        pin_en;
        logic [3:0]  pin_div;
        logic [3:0]  div_cnt;
        logic        pin_ph;
        logic        syn_rrel;
        logic        syn_en;
        logic        syn_byp;
        logic        syn_pre;
        logic [3:0]  syn_fb;
        logic [2:0]  syn_post;
        logic [2:0]  lock_sync;
        logic        lock_q;
        logic        src_ext;
        logic [5:0]  mult;
        logic [4:0]  ndiv;
    } scp_state_t;

endpackage

// ==== logic/scp_ctl.sv ====
module scp_ctl
    import scp_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_we,
    input  wire logic              reg_re,
    output logic      [DATA_W-1:0] reg_rdata,
    // event sources, same clock, high while active
    input  wire logic [EVT_N-1:0]  event_in,
    output logic                   nmi_req,
    // clock output pin
    output logic                   clock_output_pin,
    // synth macro controls
    input  wire logic              synth_lock_raw,
    input  wire logic              synth_source_select,
    output logic                   synth_reset_release,
    output logic                   synth_enable,
    output logic                   synth_bypass,
    output logic                   synth_input_divider,
    output logic [5:0]             synth_feedback_multiplier,
    output logic [4:0]             synth_output_divider,
    output logic                   synth_source_external
);

    // reset release through two flops, assert stays async
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    scp_state_t s_q;
    scp_state_t s_d;

    // feedback code to multiplier value
    function automatic logic [5:0] fb_to_m(input logic [3:0] c);
        logic [5:0] m;
        m = 6'h00;
        unique case (c)
            4'h0: m = 6'h04;
            4'h1: m = 6'h06;
            4'h2: m = 6'h08;
            4'h3: m = 6'h0a;
            4'h4: m = 6'h0c;
            4'h5: m = 6'h0e;
            4'h6: m = 6'h10;
            4'h7: m = 6'h12;
            4'h8: m = 6'h14;
            4'h9: m = 6'h18;
            4'ha: m = 6'h1a;
            4'hb: m = 6'h22;
            default: m = 6'h00; // codes never stored
        endcase
        return m;
    endfunction

    // post code to output divide value
    function automatic logic [4:0] post_to_n(input logic [2:0] c);
        logic [4:0] n;
        n = 5'h01;
        unique case (c)
            3'h0: n = 5'h01;
            3'h1: n = 5'h02;
            3'h2: n = 5'h03;
            3'h3: n = 5'h04;
            3'h4: n = 5'h06;
            3'h5: n = 5'h08;
            3'h6: n = 5'h03; // kept as printed
            3'h7: n = 5'h10;
        endcase
        return n;
    endfunction

    // decoded accesses
    logic        wr_cor;
    logic        wr_nmi;
    logic        wr_pll;
    logic        key_ok;
    logic        lock_seen;
    logic [15:0] pll_view;
    logic [31:0] nmi_view;
    logic [7:0]  cor_view;

    assign wr_cor = reg_we && (reg_addr == COR_ADDR);
    assign wr_nmi = reg_we && (reg_addr == NMI_ADDR);
    assign wr_pll = reg_we && (reg_addr == PLL_ADDR);
    assign key_ok = (reg_wdata[KEY_HI:KEY_LO] == UNLOCK_KEY);

    // lock reads true only while the synth really runs
    assign lock_seen = s_q.lock_q && s_q.syn_rrel && s_q.syn_en;

    // read views; key field reads zero since it is write only
    always_comb begin
        nmi_view = 32'h0000_0000;
        nmi_view[FLAG_HI:FLAG_LO] = s_q.evt_flag;
        nmi_view[EN_HI:EN_LO]     = s_q.evt_en;
        cor_view = 8'h00;
        cor_view[PIN_EN_BIT] = s_q.pin_en;
        cor_view[PIN_DIV_HI:PIN_DIV_LO] = s_q.pin_div;
        pll_view = 16'h0000;
        pll_view[SYN_RREL_BIT] = s_q.syn_rrel;
        pll_view[SYN_EN_BIT]   = s_q.syn_en;
        pll_view[SYN_BYP_BIT]  = s_q.syn_byp;
        pll_view[SYN_LOCK_BIT] = lock_seen;
        pll_view[SYN_PRE_BIT]  = s_q.syn_pre;
        pll_view[SYN_FB_HI:SYN_FB_LO]     = s_q.syn_fb;
        pll_view[SYN_POST_HI:SYN_POST_LO] = s_q.syn_post;
    end

    // next state of the whole block
    always_comb begin
        s_d = s_q;

        // register read, answered in the following cycle only
        s_d.rdata = 32'h0000_0000;
        if (reg_re) begin
            unique case (1'b1)
                (reg_addr == NMI_ADDR): s_d.rdata = nmi_view;
                (reg_addr == COR_ADDR): s_d.rdata = {24'h0, cor_view};
                (reg_addr == PLL_ADDR): s_d.rdata = {16'h0, pll_view};
                default:                s_d.rdata = 32'h0000_0000;
            endcase
        end

        // flags are sticky and only hardware sets them
        s_d.evt_flag = s_q.evt_flag | event_in;

        // enables change only under the right key
        if (wr_nmi && key_ok) begin
            s_d.evt_en = reg_wdata[EN_HI:EN_LO];
        end

        // registered so the nmi line carries no glitches
        s_d.nmi = |(s_q.evt_flag & s_q.evt_en);

        // clock output control
        if (wr_cor) begin
            s_d.pin_en  = reg_wdata[PIN_EN_BIT];
            s_d.pin_div = reg_wdata[PIN_DIV_HI:PIN_DIV_LO];
        end

        // divider: half period of d+1 cycles gives 2(d+1)
        if (!s_q.pin_en) begin
            s_d.div_cnt = 4'h0;
            s_d.pin_ph  = 1'b0;
        end else if (s_q.pin_div == 4'h0) begin
            s_d.div_cnt = 4'h0;
            s_d.pin_ph  = ~s_q.pin_ph;
        end else if (s_q.div_cnt >= s_q.pin_div) begin
            s_d.div_cnt = 4'h0;
            s_d.pin_ph  = ~s_q.pin_ph;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 4'h1;
        end

        // synth control
        if (wr_pll) begin
            s_d.syn_rrel = reg_wdata[SYN_RREL_BIT];
            s_d.syn_en   = reg_wdata[SYN_EN_BIT];
            s_d.syn_byp  = reg_wdata[SYN_BYP_BIT];
            s_d.syn_pre  = reg_wdata[SYN_PRE_BIT];
            s_d.syn_post = reg_wdata[SYN_POST_HI:SYN_POST_LO];
            // unavailable feedback codes are dropped
            if (reg_wdata[SYN_FB_HI:SYN_FB_LO] <= SYN_FB_LAST) begin
                s_d.syn_fb = reg_wdata[SYN_FB_HI:SYN_FB_LO];
            end
        end

        // factors handed to the synth macro
        s_d.mult = fb_to_m(s_q.syn_fb);
        s_d.ndiv = post_to_n(s_q.syn_post);

        // lock comes from the analog side: three stages
        s_d.lock_sync = {s_q.lock_sync[1:0], synth_lock_raw};
        if (s_q.lock_sync[1] == s_q.lock_sync[2]) begin
            s_d.lock_q = s_q.lock_sync[2];
        end

        // source select from the system clock register
        s_d.src_ext = synth_source_select;
    end

    // one register bank for the whole state
    always_ff @(posedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_q          <= '0;
            s_q.evt_en   <= EN_RST;
            s_q.pin_div  <= PIN_DIV_RST;
            s_q.syn_fb   <= SYN_FB_RST;
            s_q.syn_post <= SYN_POST_RST;
            s_q.mult     <= 6'h04;
            s_q.ndiv     <= 5'h01;
        end else begin
            s_q <= s_d;
        end
    end

    // falling-edge copy lets the pin run at the full clock
    // rate when the divider is zero; it stays low otherwise
    logic pin_fall_q;

    always_ff @(negedge core_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_fall_q <= 1'b0;
        end else if (s_q.pin_en && s_q.pin_div == 4'h0) begin
            pin_fall_q <= s_q.pin_ph;
        end else begin
            pin_fall_q <= 1'b0;
        end
    end

    // outputs
    assign reg_rdata                 = s_q.rdata;
    assign nmi_req                   = s_q.nmi;
    assign clock_output_pin          = s_q.pin_ph ^ pin_fall_q;
    assign synth_reset_release       = s_q.syn_rrel;
    assign synth_enable              = s_q.syn_en;
    assign synth_bypass              = s_q.syn_byp;
    assign synth_input_divider       = s_q.syn_pre;
    assign synth_feedback_multiplier = s_q.mult;
    assign synth_output_divider      = s_q.ndiv;
    assign synth_source_external     = s_q.src_ext;

endmodule

// ==== dv/scp_ctl_chk.sv ====
module scp_ctl_chk
    import scp_pkg::*;
(
    input wire logic              core_clk,
    input wire logic              arst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic              reg_we,
    input wire logic              reg_re,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [EVT_N-1:0]  event_in,
    input wire logic              nmi_req,
    input wire logic              clock_output_pin,
    input wire logic              synth_source_select,
    input wire logic              synth_reset_release,
    input wire logic              synth_enable,
    input wire logic [5:0]        synth_feedback_multiplier,
    input wire logic [4:0]        synth_output_divider,
    input wire logic              synth_source_external
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] CKO_A = 32'h4000_0050;
    logic [4:0] flg_q;
    logic [4:0] en_q;
    logic       pen_q;
    logic       cok_q;
    logic [3:0] div_q;
    logic [3:0] cnt_q;
    wire        pw = reg_we && reg_addr == PLL_ADDR;
    wire        cw = reg_we && reg_addr == CKO_A;

    function automatic logic [5:0] mv(logic [3:0] c);
        case (c)
            4'h8: return 6'h14;
            4'h9: return 6'h18;
            4'ha: return 6'h1a;
            4'hb: return 6'h22;
            default: return 6'h04 + {1'b0, c, 1'b0};
        endcase
    endfunction

    function automatic logic [4:0] nv(logic [2:0] c);
        case (c)
            3'h4: return 5'h06;
            3'h5: return 5'h08;
            3'h6: return 5'h03;
            3'h7: return 5'h10;
            default: return {2'h0, c} + 5'h01;
        endcase
    endfunction

    // mirror of flags, enables and pin setup; cok waits one edge so the
    // irregular first half period after a write is never judged
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flg_q <= 5'h00;
            en_q  <= 5'h01;
            pen_q <= 1'b0;
            div_q <= 4'h0;
            cok_q <= 1'b0;
            cnt_q <= 4'h0;
        end else begin
            flg_q <= flg_q | event_in;
            if (reg_we && reg_addr == NMI_ADDR
                && reg_wdata[31:16] == UNLOCK_KEY)
                en_q <= reg_wdata[4:0];
            if (cw) begin
                pen_q <= reg_wdata[4];
                div_q <= reg_wdata[3:0];
            end
            cok_q <= cw ? 1'b0 : (cok_q | $changed(clock_output_pin));
            cnt_q <= (cw || $changed(clock_output_pin)) ? 4'h0 : cnt_q + 4'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    property p_nmi;
        nmi_req == $past(|(flg_q & en_q));
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi level wrong");

    property p_gate_rd;
        $past(reg_re && reg_addr == NMI_ADDR) |->
            reg_rdata == {19'h0, $past(flg_q), 3'h0, $past(en_q)};
    endproperty
    a_gate_rd: assert property (p_gate_rd) else $error("gate read wrong");

    property p_pin_off;
        !pen_q && !$past(pen_q) && !$past(pen_q, 2) |-> !clock_output_pin;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin not low");

    property p_pin_per;
        cok_q && div_q != 4'h0 && $changed(clock_output_pin) |->
            cnt_q == div_q;
    endproperty
    a_pin_per: assert property (p_pin_per) else $error("pin period");

    property p_syn;
        $past(pw) |-> {synth_reset_release, synth_enable}
            == $past(reg_wdata[15:14]);
    endproperty
    a_syn: assert property (p_syn) else $error("synth ctl wrong");

    property p_fac;
        $past(pw && reg_wdata[7:4] <= 4'hb, 2) |->
            synth_feedback_multiplier == mv($past(reg_wdata[7:4], 2))
            ##0 synth_output_divider == nv($past(reg_wdata[2:0], 2));
    endproperty
    a_fac: assert property (p_fac) else $error("factor map");

    property p_fb_keep;
        $past(pw && reg_wdata[7:4] > 4'hb, 2) |->
            $stable(synth_feedback_multiplier);
    endproperty
    a_fb_keep: assert property (p_fb_keep) else $error("bad m code");

    property p_src;
        synth_source_external == $past(synth_source_select);
    endproperty
    a_src: assert property (p_src) else $error("source select");
endmodule

bind scp_ctl scp_ctl_chk chk_u (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .event_in(event_in), .nmi_req(nmi_req),
    .clock_output_pin(clock_output_pin),
    .synth_source_select(synth_source_select),
    .synth_reset_release(synth_reset_release),
    .synth_enable(synth_enable),
    .synth_feedback_multiplier(synth_feedback_multiplier),
    .synth_output_divider(synth_output_divider),
    .synth_source_external(synth_source_external)
);

// ==== dv/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import scp_pkg::*;
    localparam logic [31:0] CKO_A = 32'h4000_0050;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, reg_rdata, rv;
    logic reg_we = 1'b0, reg_re = 1'b0, nmi_req, clock_output_pin;
    logic [4:0] event_in = 5'h00, synth_output_divider;
    logic synth_lock_raw = 1'b0, synth_source_select = 1'b0;
    logic synth_reset_release, synth_enable, synth_bypass;
    logic synth_input_divider, synth_source_external;
    logic [5:0] synth_feedback_multiplier;
    int fails = 0;
    int n_tests = 0;
    int n;
    int n_tests_d [3] = '{1, 3, 15};

    always #5 core_clk = ~core_clk;

    scp_ctl dut_u (
        .core_clk                  (core_clk),
        .arst_n                    (arst_n),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .reg_we                    (reg_we),
        .reg_re                    (reg_re),
        .reg_rdata                 (reg_rdata),
        .event_in                  (event_in),
        .nmi_req                   (nmi_req),
        .clock_output_pin          (clock_output_pin),
        .synth_lock_raw            (synth_lock_raw),
        .synth_source_select       (synth_source_select),
        .synth_reset_release       (synth_reset_release),
        .synth_enable              (synth_enable),
        .synth_bypass              (synth_bypass),
        .synth_input_divider       (synth_input_divider),
        .synth_feedback_multiplier (synth_feedback_multiplier),
        .synth_output_divider      (synth_output_divider),
        .synth_source_external     (synth_source_external)
    );

    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(logic [31:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_we <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd(logic [31:0] a);
        @(posedge core_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_re <= 1'b0;
        @(negedge core_clk);
        rv = reg_rdata;
    endtask

    // skip the settling half period, then count pin changes
    task automatic edges(int k);
        logic p;
        repeat (40) @(negedge core_clk);
        p = clock_output_pin;
        n = 0;
        repeat (k) begin
            @(negedge core_clk);
            n += int'(clock_output_pin !== p);
            p = clock_output_pin;
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (4) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(NMI_ADDR); chk(rv, 32'h01);
        rd(PLL_ADDR); chk(rv, 32'h00);
        wr(NMI_ADDR, 32'h1234_1f1e);
        rd(NMI_ADDR); chk(rv, 32'h01);
        wr(NMI_ADDR, 32'ha32c_1f1e);
        rd(NMI_ADDR); chk(rv, 32'h1e);
        @(posedge core_clk) event_in <= 5'h01;
        @(posedge core_clk) event_in <= 5'h00;
        repeat (3) @(negedge core_clk);
        chk(nmi_req, 1'b0);
        rd(NMI_ADDR); chk(rv, 32'h011e);
        wr(NMI_ADDR, 32'ha32c_001f);
        repeat (2) @(negedge core_clk);
        chk(nmi_req, 1'b1);
        @(posedge core_clk) event_in <= 5'h1e;
        @(posedge core_clk) event_in <= 5'h00;
        rd(NMI_ADDR); chk(rv, 32'h1f1f);
        $display("done: event gate");
        wr(CKO_A, 32'h03);
        edges(16); chk(n, 0);
        chk(clock_output_pin, 1'b0);
        foreach (n_tests_d[i]) begin
            wr(CKO_A, 32'h10 | n_tests_d[i]);
            edges(32); chk(n, 32 / (n_tests_d[i] + 1));
        end
        wr(CKO_A, 32'h10);
        @(posedge core_clk) #2 chk(clock_output_pin, 1'b1);
        @(negedge core_clk) #2 chk(clock_output_pin, 1'b0);
        $display("done: clock pin");
        for (int i = 0; i < 16; i++)
            wr(PLL_ADDR, 32'he100 | (i << 4) | (i & 7));
        rd(PLL_ADDR); chk(rv, 32'he1b7);
        chk({synth_bypass, synth_input_divider}, 2'h3);
        synth_lock_raw <= 1'b1;
        for (int i = 0; i < 10 && rv[12] !== 1'b1; i++)
            rd(PLL_ADDR);
        chk(rv, 32'hf1b7);
        wr(PLL_ADDR, 32'h0044);
        rd(PLL_ADDR); chk(rv, 32'h0044);
        chk({synth_feedback_multiplier, synth_output_divider}, 11'h186);
        chk(synth_bypass, 1'b0);
        @(posedge core_clk) synth_source_select <= 1'b1;
        @(posedge core_clk);
        @(negedge core_clk) chk(synth_source_external, 1'b1);
        rd(32'h4000_0058); chk(rv, 32'h0);
        $display("done: synth control");
        tally_and_finish();
    end
endmodule
